// file: dcfb_top.sv
`timescale 1ns/10ps
// How it works
// - Code-protect bit 1: 1 unprotected, 0 secured
// - Write-protect bit 0: 1 writable, 0 blocked
// - Protection bits erase high, programming only clears
// - Oscillator-select bit 7 enables two-speed start-up
// - Three-bit field picks start-up clock source
// - Switch field: 1x none, 01 switch, 00 both
// - Bit 5 selects secondary oscillator high power
// - Primary range field; code 00 reserved
// - Clock output only when enabled and mode 11/00
// - Primary mode: off, HS, XT, external clock
// - Watchdog bit 7 forces on, else software
// - Watchdog bit 6 zero selects windowed mode
// - Prescaler bit chooses divide 128 or 32
// - Watchdog postscale is two to field power
// - Reset-pin bit chooses reset or plain input
// - Brown-out mode: always, active, software, off
// - Reset word bit 3 enables power-up timer
// - Debug pins: 10 pair two, 01 pair three
// - Deep-sleep watchdog and deep-sleep brown-out enables
// - Deep-sleep postscale: prescale 32, four-power times two
// - Unimplemented bits always read as zero
// - Programmed reads zero; table access at fixed addresses
module dcfb_top #(
    parameter logic [7:0] FAMILY_ID = 8'h5a,  // Arbitrary value.
    parameter logic [7:0] DEVICE_ID = 8'ha5   // Arbitrary value.
) (
    // Clock, reset and power-on erase
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic fuseRst,
    input wire logic bulkErase,

    // Table requests
    input wire logic [23:0] tblAddr,
    input wire logic tblRead,
    input wire logic tblWrite,
    input wire logic [7:0] tblWrData,
    input wire logic highVoltEntry,

    // Table answers
    output logic [23:0] tblRdData,
    output logic tblRdValid,
    output logic tblWrAck,

    // Runtime software enables
    input wire logic watchdogSwEn,
    input wire logic brownoutSwEn,

    // Segment protection
    output logic codeProtectOn,
    output logic segWriteAllowed,

    // Oscillator configuration
    output logic twoSpeedStartupEn,
    output dcfb_pkg::dcfb_clk_src_type startupClockSource,
    output logic clockSwitchEn,
    output logic failSafeMonitorEn,
    output logic secondaryOscHighPower,
    output logic [1:0] primaryFreqRange,
    output logic clockOutputOn,
    output dcfb_pkg::dcfb_posc_mode_type primaryOscMode,

    // Watchdog configuration
    output logic watchdogHwEn,
    output logic watchdogActive,
    output logic watchdogWindowEn,
    output logic [7:0] watchdogPrescale,
    output logic [3:0] watchdogPostscaleLog2,

    // Reset configuration
    output logic resetPinEn,
    output logic [1:0] brownoutLevelSel,
    output dcfb_pkg::dcfb_bor_mode_type brownoutMode,
    output logic brownoutActive,
    output logic powerupTimerEn,

    // Debug pins
    output logic progPinPairTwo,
    output logic progPinPairThree,

    // Deep sleep
    output logic deepSleepWatchdogEn,
    output logic deepSleepBrownoutEn,
    output logic [7:0] deepSleepPrescale,
    output logic [4:0] deepSleepPostscaleLog2,

    // Reserved code seen in the latched fields
    output logic configReserved
);
    import dcfb_pkg::*;

    // Fuse store contents.
    logic [7:0] fuseWord [NUM_WORDS];

    // Table answer registers.
    logic [23:0] rdData_reg;
    logic rdValid_reg;
    logic wrAck_reg;

    // Latched copies of the configuration words.
    logic [7:0] segProt_reg;
    logic [7:0] oscSel_reg;
    logic [7:0] oscCfg_reg;
    logic [7:0] wdtCfg_reg;
    logic [7:0] rstCfg_reg;
    logic [7:0] dbgCfg_reg;
    logic [7:0] dslpCfg_reg;

    // Maps a table address onto a fuse word index; hit is low on a miss.
    function automatic logic [3:0] addrToIdx(input logic [23:0] addr);
        case (addr)
            SEG_PROT_ADDR: addrToIdx = {1'b1, IDX_SEG_PROT};
            OSC_SEL_ADDR: addrToIdx = {1'b1, IDX_OSC_SEL};
            OSC_CFG_ADDR: addrToIdx = {1'b1, IDX_OSC_CFG};
            WDT_CFG_ADDR: addrToIdx = {1'b1, IDX_WDT_CFG};
            RST_CFG_ADDR: addrToIdx = {1'b1, IDX_RST_CFG};
            DBG_CFG_ADDR: addrToIdx = {1'b1, IDX_DBG_CFG};
            DSLP_CFG_ADDR: addrToIdx = {1'b1, IDX_DSLP_CFG};
            default: addrToIdx = 4'h0;
        endcase
    endfunction

    // Implemented-bit mask of a word index.
    function automatic logic [7:0] idxMask(input logic [2:0] idx);
        case (idx)
            IDX_SEG_PROT: idxMask = SEG_PROT_MASK;
            IDX_OSC_SEL: idxMask = OSC_SEL_MASK;
            IDX_OSC_CFG: idxMask = OSC_CFG_MASK;
            IDX_WDT_CFG: idxMask = WDT_CFG_MASK;
            IDX_RST_CFG: idxMask = RST_CFG_MASK;
            IDX_DBG_CFG: idxMask = DBG_CFG_MASK;
            IDX_DSLP_CFG: idxMask = DSLP_CFG_MASK;
            default: idxMask = 8'h00;
        endcase
    endfunction

    // Address decode for the table port.
    wire [3:0] decodeHit = addrToIdx(tblAddr);
    wire cfgHit = decodeHit[3];
    wire [2:0] cfgIdx = decodeHit[2:0];
    wire idHit = (tblAddr == DEV_ID_ADDR);
    wire [7:0] cfgMask = idxMask(cfgIdx);

    // Only configuration words accept programming; the identifier is fixed.
    wire progStrobe = tblWrite && cfgHit;

    // The reset-pin bit is frozen unless the part entered programming through
    // the high-voltage path, so a low-voltage entry can never be locked out.
    wire rstPinGuard = (cfgIdx == IDX_RST_CFG) && !highVoltEntry;
    wire [7:0] rstPinBitMask = 8'h01 << RST_PIN_BIT;
    wire [7:0] keepMask = ~cfgMask | (rstPinGuard ? rstPinBitMask : 8'h00);

    dcfb_fuse_store u_store (
        .sys_clk(sys_clk),
        .fuseRst(fuseRst),
        .bulkErase(bulkErase),
        .progStrobe(progStrobe),
        .progIdx(cfgIdx),
        .progData(tblWrData),
        .progKeep(keepMask),
        .wordOut(fuseWord)
    );

    // A configuration word fills the low byte; its unimplemented bits and the
    // upper two bytes read zero.
    wire [7:0] cfgReadByte = fuseWord[cfgIdx] & cfgMask;
    wire [23:0] cfgReadWord = {16'h0000, cfgReadByte};

    // The identifier's top byte is unimplemented and reads zero.
    wire [23:0] idReadWord = {8'h00, FAMILY_ID, DEVICE_ID};

    // Unmapped addresses read zero rather than a stale word.
    wire [23:0] readMux = cfgHit ? cfgReadWord :
                          idHit ? idReadWord : 24'h000000;

    // Table read data is registered and held until the next read.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData_reg <= 24'h000000;
        end else if (tblRead) begin
            rdData_reg <= readMux;
        end
    end

    // Read valid is a one-cycle pulse in the cycle after the request.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdValid_reg <= 1'b0;
        end else begin
            rdValid_reg <= tblRead;
        end
    end

    // Write acknowledge pulses once for each accepted configuration write.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrAck_reg <= 1'b0;
        end else begin
            wrAck_reg <= progStrobe;
        end
    end

    assign tblRdData = rdData_reg;
    assign tblRdValid = rdValid_reg;
    assign tblWrAck = wrAck_reg;

    // Segment word snapshot. Every snapshot is taken while reset is held and
    // frozen after, so a reprogrammed fuse only takes effect at the next
    // reset; that keeps the consumers free of glitches from a write in
    // mid-operation.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            segProt_reg <= fuseWord[IDX_SEG_PROT];
        end
    end

    // Oscillator selection word snapshot.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oscSel_reg <= fuseWord[IDX_OSC_SEL];
        end
    end

    // Oscillator configuration word snapshot.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oscCfg_reg <= fuseWord[IDX_OSC_CFG];
        end
    end

    // Watchdog word snapshot.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wdtCfg_reg <= fuseWord[IDX_WDT_CFG];
        end
    end

    // Reset word snapshot.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rstCfg_reg <= fuseWord[IDX_RST_CFG];
        end
    end

    // Debug pin word snapshot.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dbgCfg_reg <= fuseWord[IDX_DBG_CFG];
        end
    end

    // Deep-sleep word snapshot.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dslpCfg_reg <= fuseWord[IDX_DSLP_CFG];
        end
    end

    // Segment protection; a programmed bit reads zero and means protected.
    assign codeProtectOn = !segProt_reg[CODE_PROT_BIT];
    assign segWriteAllowed = segProt_reg[SEG_WRP_BIT];

    // Start-up clock selection.
    assign twoSpeedStartupEn = oscSel_reg[TWO_SPEED_BIT];
    assign startupClockSource =
        dcfb_clk_src_type'(oscSel_reg[CLK_SRC_LSB +: 3]);

    // Clock switching: the upper bit set disables both features.
    wire [1:0] clkSwField = oscCfg_reg[CLK_SW_LSB +: 2];
    assign clockSwitchEn = !clkSwField[1];
    assign failSafeMonitorEn = (clkSwField == 2'h0);

    // Secondary oscillator drive and primary range.
    assign secondaryOscHighPower = oscCfg_reg[SOSC_PWR_BIT];
    assign primaryFreqRange = oscCfg_reg[FREQ_RANGE_LSB +: 2];
    wire freqReserved = (primaryFreqRange == FREQ_RESERVED);

    // Primary oscillator mode.
    assign primaryOscMode =
        dcfb_posc_mode_type'(oscCfg_reg[POSC_MODE_LSB +: 2]);

    // The clock output pin is shared with the crystal, so it is only driven
    // when the crystal drivers are idle.
    wire oscPinFree = (primaryOscMode == POSC_DISABLED) ||
                      (primaryOscMode == POSC_EXT_CLOCK);
    assign clockOutputOn = oscCfg_reg[CLK_OUT_BIT] && oscPinFree;

    // Watchdog; the software enable only counts when the fuse leaves it free.
    assign watchdogHwEn = wdtCfg_reg[WDT_HW_BIT];
    assign watchdogActive = watchdogHwEn || watchdogSwEn;

    // Watchdog window and timing ratios.
    assign watchdogWindowEn = !wdtCfg_reg[WDT_WIN_BIT];
    assign watchdogPrescale =
        wdtCfg_reg[WDT_PRE_BIT] ? WDT_PRE_LONG : WDT_PRE_SHORT;
    assign watchdogPostscaleLog2 = wdtCfg_reg[WDT_POST_LSB +: 4];

    // Reset pin function.
    assign resetPinEn = rstCfg_reg[RST_PIN_BIT];

    // Brown-out level and mode, and the power-up timer.
    assign brownoutLevelSel = rstCfg_reg[BOR_LEVEL_LSB +: 2];
    assign brownoutMode =
        dcfb_bor_mode_type'(rstCfg_reg[BOR_MODE_LSB +: 2]);
    assign powerupTimerEn = rstCfg_reg[PWRT_BIT];

    // Brown-out enable while awake; sleep gating is left to the consumer
    // through brownoutMode, since sleep state is not visible here.
    logic borAwake;
    always_comb begin
        case (brownoutMode)
            BOR_ALWAYS: borAwake = 1'b1;
            BOR_ACTIVE_ONLY: borAwake = 1'b1;
            BOR_SOFTWARE: borAwake = brownoutSwEn;
            BOR_DISABLED: borAwake = 1'b0;
            default: borAwake = 1'b0;
        endcase
    end
    assign brownoutActive = borAwake;

    // Programming pin pair; reserved codes select neither pair.
    wire [1:0] dbgField = dbgCfg_reg[DBG_PAIR_LSB +: 2];
    assign progPinPairTwo = (dbgField == DBG_PAIR_TWO);
    assign progPinPairThree = (dbgField == DBG_PAIR_THREE);

    // Codes 00 and 11 are reserved; catch them for the flag below.
    wire dbgReserved = !progPinPairTwo && !progPinPairThree;

    // Deep-sleep enables; the brown-out bit has no effect outside deep sleep.
    assign deepSleepWatchdogEn = dslpCfg_reg[DSWDT_BIT];
    assign deepSleepBrownoutEn = dslpCfg_reg[DSBOR_BIT];

    // Deep-sleep watchdog: ratio is 2 * 4^n, so its log2 is 2n + 1.
    wire [3:0] dsField = dslpCfg_reg[DS_POST_LSB +: 4];
    assign deepSleepPrescale = DS_PRESCALE;
    assign deepSleepPostscaleLog2 = {dsField, 1'b1};

    // Flags a reserved code so firmware or test can spot a bad image.
    assign configReserved = freqReserved || dbgReserved;

endmodule

// file: dcfb_pkg.sv
package dcfb_pkg;

    // Configuration memory map, byte addresses in the table space.
    localparam logic [23:0] CFG_BASE_ADDR = 24'hf80000;
    localparam logic [23:0] SEG_PROT_ADDR = 24'hf80004;
    localparam logic [23:0] OSC_SEL_ADDR = 24'hf80006;
    localparam logic [23:0] OSC_CFG_ADDR = 24'hf80008;
    localparam logic [23:0] WDT_CFG_ADDR = 24'hf8000a;
    localparam logic [23:0] RST_CFG_ADDR = 24'hf8000c;
    localparam logic [23:0] DBG_CFG_ADDR = 24'hf8000e;
    localparam logic [23:0] DSLP_CFG_ADDR = 24'hf80010;
    localparam logic [23:0] DEV_ID_ADDR = 24'hff0000;

    // Word indices inside the fuse store.
    localparam int NUM_WORDS = 7;
    localparam logic [2:0] IDX_SEG_PROT = 3'h0;
    localparam logic [2:0] IDX_OSC_SEL = 3'h1;
    localparam logic [2:0] IDX_OSC_CFG = 3'h2;
    localparam logic [2:0] IDX_WDT_CFG = 3'h3;
    localparam logic [2:0] IDX_RST_CFG = 3'h4;
    localparam logic [2:0] IDX_DBG_CFG = 3'h5;
    localparam logic [2:0] IDX_DSLP_CFG = 3'h6;

    // Implemented-bit masks; the erased value of each word equals its mask.
    localparam logic [7:0] SEG_PROT_MASK = 8'h03;
    localparam logic [7:0] OSC_SEL_MASK = 8'h87;
    localparam logic [7:0] OSC_CFG_MASK = 8'hff;
    localparam logic [7:0] WDT_CFG_MASK = 8'hdf;
    localparam logic [7:0] RST_CFG_MASK = 8'he3 | 8'h08;
    localparam logic [7:0] DBG_CFG_MASK = 8'h03;
    localparam logic [7:0] DSLP_CFG_MASK = 8'hcf;

    // Field positions.
    localparam int CODE_PROT_BIT = 1;
    localparam int SEG_WRP_BIT = 0;
    localparam int TWO_SPEED_BIT = 7;
    localparam int CLK_SRC_LSB = 0;
    localparam int CLK_SW_LSB = 6;
    localparam int SOSC_PWR_BIT = 5;
    localparam int FREQ_RANGE_LSB = 3;
    localparam int CLK_OUT_BIT = 2;
    localparam int POSC_MODE_LSB = 0;
    localparam int WDT_HW_BIT = 7;
    localparam int WDT_WIN_BIT = 6;
    localparam int WDT_PRE_BIT = 4;
    localparam int WDT_POST_LSB = 0;
    localparam int RST_PIN_BIT = 7;
    localparam int BOR_LEVEL_LSB = 5;
    localparam int PWRT_BIT = 3;
    localparam int BOR_MODE_LSB = 0;
    localparam int DBG_PAIR_LSB = 0;
    localparam int DSWDT_BIT = 7;
    localparam int DSBOR_BIT = 6;
    localparam int DS_POST_LSB = 0;

    // Watchdog ratios and the deep-sleep prescale.
    localparam logic [7:0] WDT_PRE_LONG = 8'h80;
    localparam logic [7:0] WDT_PRE_SHORT = 8'h20;
    localparam logic [7:0] DS_PRESCALE = 8'h20;

    // Field encodings.
    typedef enum logic [2:0] {
        CLK_FAST_RC, CLK_FAST_RC_DIV_PLL, CLK_PRIMARY, CLK_PRIMARY_PLL,
        CLK_SECONDARY, CLK_LOW_POWER_RC, CLK_LP_FAST_RC_DIV, CLK_FAST_RC_DIV
    } dcfb_clk_src_type;
    typedef enum logic [1:0] {
        POSC_EXT_CLOCK, POSC_STD_CRYSTAL, POSC_HS_CRYSTAL, POSC_DISABLED
    } dcfb_posc_mode_type;
    typedef enum logic [1:0] {
        BOR_DISABLED, BOR_SOFTWARE, BOR_ACTIVE_ONLY, BOR_ALWAYS
    } dcfb_bor_mode_type;
    localparam logic [1:0] FREQ_RESERVED = 2'h0;
    localparam logic [1:0] DBG_PAIR_TWO = 2'h2;
    localparam logic [1:0] DBG_PAIR_THREE = 2'h1;

endpackage

// file: dcfb_fuse_store.sv
`timescale 1ns/10ps
// Non-volatile configuration words: programming only clears bits, an
// erase returns every implemented bit to one.
module dcfb_fuse_store (
    // Clock and power-on erase
    input wire logic sys_clk,
    input wire logic fuseRst,
    input wire logic bulkErase,
    // Program port
    input wire logic progStrobe,
    input wire logic [2:0] progIdx,
    input wire logic [7:0] progData,
    input wire logic [7:0] progKeep,
    // Stored words
    output logic [7:0] wordOut [dcfb_pkg::NUM_WORDS]
);
    import dcfb_pkg::*;

    logic [7:0] mem_reg [NUM_WORDS];

    // Erased value of each word; unimplemented bits stay zero.
    function automatic logic [7:0] erasedWord(input int idx);
        case (idx)
            0: erasedWord = SEG_PROT_MASK;
            1: erasedWord = OSC_SEL_MASK;
            2: erasedWord = OSC_CFG_MASK;
            3: erasedWord = WDT_CFG_MASK;
            4: erasedWord = RST_CFG_MASK;
            5: erasedWord = DBG_CFG_MASK;
            6: erasedWord = DSLP_CFG_MASK;
            default: erasedWord = 8'h00;
        endcase
    endfunction

    // A write may clear a bit but never set it back; erase is the only way up.
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NUM_WORDS; i++) begin
            if (fuseRst || bulkErase) begin
                mem_reg[i] <= erasedWord(i);
            end else if (progStrobe && progIdx == i[2:0]) begin
                mem_reg[i] <= mem_reg[i] & (progData | progKeep);
            end
        end
    end

    assign wordOut = mem_reg;

endmodule

// file: dcfb_top_asserts.sv
`timescale 1ns/10ps
// Watches the table port and the latched configuration outputs.
module dcfb_top_asserts #(
    parameter logic [7:0] FAMILY_ID = 8'h5a,  // Arbitrary value.
    parameter logic [7:0] DEVICE_ID = 8'ha5   // Arbitrary value.
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Table port
    input wire logic [23:0] tblAddr,
    input wire logic tblRead,
    input wire logic tblWrite,
    input wire logic [23:0] tblRdData,
    input wire logic tblRdValid,
    input wire logic tblWrAck,
    // Decoded fields
    input wire logic codeProtectOn,
    input wire logic clockSwitchEn,
    input wire logic failSafeMonitorEn,
    input wire logic clockOutputOn,
    input wire logic [1:0] primaryOscMode,
    input wire logic [7:0] watchdogPrescale,
    input wire logic resetPinEn,
    input wire logic progPinPairTwo,
    input wire logic progPinPairThree
);
    import dcfb_pkg::*;

    // Even byte addresses of the seven configuration words.
    wire logic cfgAddr = tblAddr >= SEG_PROT_ADDR &&
        tblAddr <= DSLP_CFG_ADDR && !tblAddr[0];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    read_answer_a: assert property (tblRead |=> tblRdValid)
        else $error("read not answered");
    no_spur_valid_a: assert property (!tblRead |=> !tblRdValid)
        else $error("read valid without request");
    write_ack_a: assert property (tblWrite && cfgAddr |=> tblWrAck)
        else $error("config write not acknowledged");
    foreign_write_a: assert property (tblWrite && !cfgAddr |=> !tblWrAck)
        else $error("write outside config words acknowledged");
    ident_read_a: assert property (tblRead && tblAddr == DEV_ID_ADDR |=>
        tblRdData == {8'h00, FAMILY_ID, DEVICE_ID})
        else $error("identifier read wrong");
    seg_unused_a: assert property (tblRead && tblAddr == SEG_PROT_ADDR |=>
        tblRdData[23:2] == 22'h0)
        else $error("unused segment bits not zero");
    rdata_hold_a: assert property (!tblRead |=> $stable(tblRdData))
        else $error("read data moved without read");
    clk_out_a: assert property (clockOutputOn |->
        primaryOscMode inside {POSC_DISABLED, POSC_EXT_CLOCK})
        else $error("clock output with crystal mode");
    fail_safe_a: assert property (failSafeMonitorEn |-> clockSwitchEn)
        else $error("monitor without switching");
    wdt_prescale_a: assert property (watchdogPrescale == WDT_PRE_LONG ||
        watchdogPrescale == WDT_PRE_SHORT)
        else $error("watchdog prescale illegal");
    pin_pair_a: assert property (!(progPinPairTwo && progPinPairThree))
        else $error("two pin pairs selected");
    fields_static_a: assert property (!$past(rst) |-> $stable({codeProtectOn,
        resetPinEn, clockOutputOn, primaryOscMode}))
        else $error("latched field changed outside reset");

    // Main scenarios reached.
    cover property (tblRead && tblAddr == DEV_ID_ADDR);
    cover property (tblWrite ##1 tblWrAck);
    cover property (clockOutputOn);
endmodule

bind dcfb_top dcfb_top_asserts #(.FAMILY_ID(FAMILY_ID),
    .DEVICE_ID(DEVICE_ID)) i_chk (.*);

// file: dcfb_prog_model.sv
`timescale 1ns/10ps
// Table programmer: one request per call, released the cycle after.
module dcfb_prog_model (
    // Clock
    input wire logic sys_clk,
    // Table requests
    output logic [23:0] tblAddr,
    output logic tblRead,
    output logic tblWrite,
    output logic [7:0] tblWrData,
    output logic highVoltEntry
);
    import dcfb_pkg::*;

    // Idle state at time zero.
    initial begin
        tblAddr = CFG_BASE_ADDR;
        tblRead = 1'h0;
        tblWrite = 1'h0;
        tblWrData = 8'h00;
        highVoltEntry = 1'h0;
    end

    // Released address and data show the inverse, so a stale value never matches.
    task automatic req(input logic rd, input logic [23:0] a,
                       input logic [7:0] d, input logic hv);
        @(negedge sys_clk);
        tblAddr = a;
        tblWrData = d;
        highVoltEntry = hv;
        tblRead = rd;
        tblWrite = !rd;
        @(negedge sys_clk);
        tblRead = 1'h0;
        tblWrite = 1'h0;
        tblAddr = ~a;
        tblWrData = ~d;
        highVoltEntry = 1'h0;
    endtask
endmodule

// file: test_device_configuration_fuse_bank.sv
`timescale 1ns/10ps
module test_device_configuration_fuse_bank;
    import dcfb_pkg::*;

    localparam logic [7:0] FAM_ID = 8'h3c; // Arbitrary value.
    localparam logic [7:0] DEV_ID = 8'hc3; // Arbitrary value.
    localparam logic [7:0] MSK [7] = '{SEG_PROT_MASK, OSC_SEL_MASK,
        OSC_CFG_MASK, WDT_CFG_MASK, RST_CFG_MASK, DBG_CFG_MASK, DSLP_CFG_MASK};

    logic sys_clk = 1'h0, rst = 1'h1, fuseRst = 1'h1, bulkErase = 1'h0;
    logic watchdogSwEn = 1'h0, brownoutSwEn = 1'h0, highVoltEntry;
    logic tblRead, tblWrite, tblRdValid, tblWrAck, configReserved;
    logic [23:0] tblAddr, tblRdData;
    logic [7:0] tblWrData, watchdogPrescale, deepSleepPrescale;
    logic codeProtectOn, segWriteAllowed, twoSpeedStartupEn, clockSwitchEn;
    logic failSafeMonitorEn, secondaryOscHighPower, clockOutputOn;
    logic watchdogHwEn, watchdogActive, watchdogWindowEn, resetPinEn;
    logic brownoutActive, powerupTimerEn, progPinPairTwo, progPinPairThree;
    logic deepSleepWatchdogEn, deepSleepBrownoutEn;
    logic [1:0] primaryFreqRange, brownoutLevelSel;
    logic [3:0] watchdogPostscaleLog2;
    logic [4:0] deepSleepPostscaleLog2;
    dcfb_clk_src_type startupClockSource;
    dcfb_posc_mode_type primaryOscMode;
    dcfb_bor_mode_type brownoutMode;
    logic [7:0] wExp [7];
    logic [23:0] rdQueue [$];
    int errorCnt = 0, checkCount = 0, cycles = 0;

    dcfb_top #(.FAMILY_ID(FAM_ID), .DEVICE_ID(DEV_ID)) i_dut (.*);
    dcfb_prog_model i_prog (.*);

    // Clock of 50 ns period.
    always #25 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] a);
        checkCount++;
        if (a !== e) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, a);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Cut a hang short; the whole run needs under three hundred cycles.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errorCnt++;
            stop_test();
        end
    end

    // Each read answer is matched to the oldest noted expectation.
    always @(negedge sys_clk) begin
        if (tblRdValid === 1'h1) begin
            if (rdQueue.size() == 0)
                chk("rdExtra", 64'h0, 64'h1);
            else chk("tblRdData", rdQueue.pop_front(), tblRdData);
        end
    end

    task automatic rd(input logic [23:0] a, input logic [23:0] e);
        rdQueue.push_back(e);
        i_prog.req(1'h1, a, 8'h00, 1'h0);
    endtask

    // Programming only clears; the reset-pin bit needs high voltage.
    task automatic wr(input int i, input logic [7:0] d, input logic hv);
        logic keep;
        keep = wExp[4][7];
        wExp[i] = wExp[i] & (d | ~MSK[i]);
        if (i == 4 && hv !== 1'h1) wExp[4][7] = keep;
        i_prog.req(1'h0, SEG_PROT_ADDR + 24'(2 * i), d, hv);
        chk("tblWrAck", 64'h1, tblWrAck);
    endtask

    task automatic rd_all();
        for (int i = 0; i < 7; i++)
            rd(SEG_PROT_ADDR + 24'(2 * i), {16'h0, wExp[i]});
        rd(DEV_ID_ADDR, {8'h00, FAM_ID, DEV_ID});
        rd(CFG_BASE_ADDR, 24'h0);
    endtask

    // Pulse reset with fresh software enables, then compare every field.
    task automatic reboot();
        logic [7:0] s, o, c, d, r, g, p;
        logic [53:0] e;
        {s, o, c, d, r, g, p} = {wExp[0], wExp[1], wExp[2], wExp[3],
            wExp[4], wExp[5], wExp[6]};
        @(negedge sys_clk);
        rst = 1'h1;
        watchdogSwEn = 1'($urandom);
        brownoutSwEn = 1'($urandom);
        @(negedge sys_clk);
        rst = 1'h0;
        @(negedge sys_clk);
        e = {!s[1], s[0], o[7], o[2:0], !c[7], c[7:6] == 2'h0, c[5], c[4:3],
            c[2] && (c[1:0] == 2'h3 || c[1:0] == 2'h0), c[1:0], d[7],
            d[7] | watchdogSwEn, !d[6], d[4] ? WDT_PRE_LONG : WDT_PRE_SHORT,
            d[3:0], r[7], r[6:5], r[1:0], r[1] | (r[0] & brownoutSwEn), r[3],
            g[1:0] == DBG_PAIR_TWO, g[1:0] == DBG_PAIR_THREE, p[7], p[6],
            DS_PRESCALE, p[3:0], 1'h1,
            c[4:3] == FREQ_RESERVED || g[1:0] == 2'h0 || g[1:0] == 2'h3};
        chk("fields", e, {codeProtectOn, segWriteAllowed, twoSpeedStartupEn,
            startupClockSource, clockSwitchEn, failSafeMonitorEn,
            secondaryOscHighPower, primaryFreqRange, clockOutputOn,
            primaryOscMode, watchdogHwEn, watchdogActive, watchdogWindowEn,
            watchdogPrescale, watchdogPostscaleLog2, resetPinEn,
            brownoutLevelSel, brownoutMode, brownoutActive, powerupTimerEn,
            progPinPairTwo, progPinPairThree, deepSleepWatchdogEn,
            deepSleepBrownoutEn, deepSleepPrescale, deepSleepPostscaleLog2,
            configReserved});
    endtask

    // Erase, check erased fields, program at random, read back, relatch.
    initial begin
        void'($urandom(35736));
        repeat (16) @(negedge sys_clk);
        rst = 1'h0;
        fuseRst = 1'h0;
        for (int k = 0; k < 4; k++) begin
            if (k > 0) begin
                @(negedge sys_clk);
                bulkErase = 1'h1;
                @(negedge sys_clk);
                bulkErase = 1'h0;
            end
            wExp = MSK;
            reboot();
            rd_all();
            for (int i = 0; i < 7; i++) wr(i, 8'($urandom), 1'(k));
            wr(0, 8'hff, 1'h0);
            wr(4, 8'h00, 1'h0);
            i_prog.req(1'h0, DEV_ID_ADDR, 8'h00, 1'h0);
            chk("idAck", 64'h0, tblWrAck);
            rd_all();
            reboot();
        end
        repeat (4) @(negedge sys_clk);
        chk("rdLeft", 64'h0, 64'(rdQueue.size()));
        stop_test();
    end
endmodule
